// >>> shared/tap_bridge_params.svh
// register offsets, field positions, reset values and tap patterns of the tap master bridge
`ifndef TAP_BRIDGE_PARAMS_SVH
`define TAP_BRIDGE_PARAMS_SVH

// host register offsets on the three address pins
`define ADDR_CFG_A 3'h0
`define ADDR_CFG_B 3'h1
`define ADDR_STATUS 3'h2
`define ADDR_COMMAND 3'h3
`define ADDR_TDO_BUF 3'h4
`define ADDR_TDI_BUF 3'h5
`define ADDR_COUNTER 3'h6
`define ADDR_DISCRETE 3'h7

// reset values
`define RST_CFG_A 8'h00
`define RST_CFG_B 8'h80
`define RST_COUNTER 8'h00
`define RST_DISCRETE 4'h0

// configuration field positions
`define CFGA_MODE_MSB 1
`define CFGA_MODE_LSB 0
`define CFGB_DIV_MSB 7
`define CFGB_DIV_LSB 5
`define CFGB_RDLY_MSB 3
`define CFGB_RDLY_LSB 0

// command field positions
`define CMD_SOFT_RST_BIT 7
`define CMD_TRST_BIT 6
`define CMD_OP_MSB 3
`define CMD_OP_LSB 0

// discrete-control field positions
`define DISC_TRST_BIT 3
`define DISC_TMS_BIT 2
`define DISC_TDO_BIT 0

// tms patterns, sent lsb first, with their lengths
`define PAT_TAP_RESET 8'h1F
`define LEN_TAP_RESET 4'h6
`define PAT_SCAN_DR 8'h01
`define LEN_SCAN_DR 4'h3
`define PAT_SCAN_IR 8'h03
`define LEN_SCAN_IR 4'h4
`define PAT_EXIT 8'h01
`define LEN_EXIT 4'h2

`endif

// >>> shared/tap_bridge_pkg.sv
// types shared by the tap master bridge
package tap_bridge_pkg;

  // sequence engine states, gray along idle-pre-shift-post-drain
  typedef enum logic [2:0] {
    ENG_IDLE = 3'h0,
    ENG_PRE = 3'h1,
    ENG_SHIFT = 3'h3,
    ENG_POST = 3'h2,
    ENG_DRAIN = 3'h6
  } engine_state_t;

  // command opcodes
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_TAP_RESET = 4'h1,
    OP_SCAN_DR = 4'h2,
    OP_SCAN_IR = 4'h3,
    OP_SHADOW = 4'h4
  } opcode_t;

  // test clock modes
  typedef enum logic [1:0] {
    MODE_FREE = 2'h0,
    MODE_GATED = 2'h1,
    MODE_DISCRETE = 2'h2
  } tck_mode_t;

endpackage

// >>> verilog/tck_tick_gen.sv
// test clock divider producing one tick per half period
`timescale 1ns/1ps
module tck_tick_gen #(
  parameter int DIV_W = 3, // width of the divisor select
  parameter int CNT_W = 8  // width of the half-period counter
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic [DIV_W-1:0] div_sel_i,
  output logic tick_o
);

  logic [CNT_W-1:0] half_last; // last count of a half period
  logic [CNT_W-1:0] count; // position inside the half period

  // full period is two to the power of the select, two at least
  always_comb begin
    if (div_sel_i == '0) begin
      half_last = '0;
    end else begin
      half_last = CNT_W'(((32'h1 << div_sel_i) >> 1) - 32'h1);
    end
  end

  // counter holds while stopped so the clock resumes in phase
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      count <= '0;
    end else if (run_i) begin
      if (count >= half_last) begin
        count <= '0;
      end else begin
        count <= count + CNT_W'(1);
      end
    end
  end

  // gated by run so a stall takes effect in the same cycle
  assign tick_o = run_i && (count >= half_last);

endmodule

// >>> verilog/tap_master_host_bridge.sv
// boundary-scan tap master with a byte-wide host port
//
// Functional notes
// - drive test data out on falling tck
// - drive tms on falling tck
// - drive enable high floats all tap outputs
// - target reset low only on host write
// - source tck tms tdo trst, receive tdi
// - byte-wide peripheral port, memory or io
// - generate states, serialise and deserialise bytes
// - drop ready while an access is blocked
// - finish blocked access when block clears
// - blocking conditions visible in status, command
// - discrete mode gives free tms/tdo control
// - gated mode stops tck for buffer service
// - realign returned data for pipeline delay
// - gated mode shadow protocol scan command
// - data and instruction register scan commands
// - host, discrete, tck, state, tdo, tdi blocks
// - sample returned data on rising tck
// - tck is system clock over divisor
// - discrete read raises, write lowers tck
// - ready high when strobe ends access
`timescale 1ns/1ps
`include "tap_bridge_params.svh"
module tap_master_host_bridge #(
  parameter int RDLY_MAX = 15 // deepest pipeline delay compensated
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic access_strobe_n_i,
  input wire logic rw_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic ready_o,
  input wire logic tap_drive_enable_n_i,
  input wire logic tdi_i,
  output logic tck_o,
  output logic tck_oe_o,
  output logic tms_o,
  output logic tms_oe_o,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic trst_n_o,
  output logic trst_oe_o
);

  // pin synchronisers, stage one feeds stage two only
  logic access_strobe_n_s1, access_strobe_n_s2, access_strobe_n_s3; // s3 is the edge history
  logic rw_s1, rw_s2;
  logic [2:0] addr_s1, addr_s2;
  logic [7:0] data_s1, data_s2;
  logic toe_n_s1, toe_n_s2;
  logic tdi_s1, tdi_s2;

  // host registers
  logic [7:0] cfg_a; // mode select
  logic [7:0] cfg_b; // divisor and retiming delay
  logic [7:0] counter; // scan length in bytes
  logic trst_cmd; // target reset requested by command
  tap_bridge_pkg::opcode_t opcode; // non-zero while a command runs
  logic [3:0] disc_reg; // discrete trst, tms, unused, tdo

  // engine state
  tap_bridge_pkg::engine_state_t state;
  logic [7:0] tms_pat; // remaining tms pattern bits
  logic [3:0] pat_cnt; // bits left in the pattern
  logic [7:0] bytes_left; // bytes still to shift
  logic [2:0] bit_idx; // bit within the current byte
  logic [7:0] tdo_shift; // outgoing byte being serialised
  logic shift_mark; // a data bit was driven at the last fall, outside shadow commands
  logic shadow; // shadow protocol command running
  logic eng_tms, eng_tdo; // engine pin values
  logic phase; // internal tck level
  logic disc_tck; // tck level in discrete mode
  logic [RDLY_MAX-1:0] vline; // marks of driven bits, by rise
  logic [RDLY_MAX-1:0] live_mask; // taps that can still feed a capture

  // buffers
  logic [7:0] tdo_buf;
  logic tdo_full;
  logic [7:0] tdi_buf;
  logic tdi_full;
  logic [7:0] tdi_shift; // incoming byte being assembled
  logic [2:0] tdi_cnt;

  // combinational helpers
  tap_bridge_pkg::tck_mode_t mode;
  logic [3:0] rdly;
  logic busy, active, access_end, block_cond, grant;
  logic wr_cmd, soft_rst, wr_tdo, rd_tdi, wr_disc, rd_disc;
  logic tick, rise_ev, fall_ev, run, stall, eng_load, delayed_valid;
  logic [7:0] rd_mux;

  assign mode = tap_bridge_pkg::tck_mode_t'(cfg_a[`CFGA_MODE_MSB:`CFGA_MODE_LSB]);
  assign rdly = cfg_b[`CFGB_RDLY_MSB:`CFGB_RDLY_LSB];
  assign busy = (opcode != tap_bridge_pkg::OP_NONE);

  // two flip-flops on every pin input, three on the access strobe
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      access_strobe_n_s1 <= 1'b1;
      access_strobe_n_s2 <= 1'b1;
      access_strobe_n_s3 <= 1'b1;
      rw_s1 <= 1'b1;
      rw_s2 <= 1'b1;
      addr_s1 <= 3'h0;
      addr_s2 <= 3'h0;
      data_s1 <= 8'h00;
      data_s2 <= 8'h00;
      toe_n_s1 <= 1'b1;
      toe_n_s2 <= 1'b1;
      tdi_s1 <= 1'b1;
      tdi_s2 <= 1'b1;
    end else begin
      access_strobe_n_s1 <= access_strobe_n_i;
      access_strobe_n_s2 <= access_strobe_n_s1;
      access_strobe_n_s3 <= access_strobe_n_s2;
      rw_s1 <= rw_i;
      rw_s2 <= rw_s1;
      addr_s1 <= addr_i;
      addr_s2 <= addr_s1;
      data_s1 <= data_i;
      data_s2 <= data_s1;
      toe_n_s1 <= tap_drive_enable_n_i;
      toe_n_s2 <= toe_n_s1;
      tdi_s1 <= tdi_i;
      tdi_s2 <= tdi_s1;
    end
  end

  // host access decode; effects take place when the strobe ends
  assign active = !access_strobe_n_s2;
  assign access_end = access_strobe_n_s2 && !access_strobe_n_s3;

  // every blocking cause is a status or command bit the host can poll
  always_comb begin
    block_cond = 1'b0;
    if (rw_s2) begin
      block_cond = (addr_s2 == `ADDR_TDI_BUF) && !tdi_full;
    end else begin
      case (addr_s2)
        `ADDR_TDO_BUF: block_cond = tdo_full;
        `ADDR_CFG_A, `ADDR_CFG_B, `ADDR_COUNTER: block_cond = busy;
        `ADDR_COMMAND: block_cond = busy && !data_s2[`CMD_SOFT_RST_BIT];
        default: block_cond = 1'b0;
      endcase
    end
  end

  // an access ended while still blocked is dropped; the host must not rely on it
  assign grant = access_end && !block_cond;
  assign wr_cmd = grant && !rw_s2 && (addr_s2 == `ADDR_COMMAND);
  assign soft_rst = wr_cmd && data_s2[`CMD_SOFT_RST_BIT];
  assign wr_tdo = grant && !rw_s2 && (addr_s2 == `ADDR_TDO_BUF);
  assign rd_tdi = grant && rw_s2 && (addr_s2 == `ADDR_TDI_BUF);
  assign wr_disc = grant && !rw_s2 && (addr_s2 == `ADDR_DISCRETE) &&
                   (mode == tap_bridge_pkg::MODE_DISCRETE) && !busy;
  assign rd_disc = grant && rw_s2 && (addr_s2 == `ADDR_DISCRETE) &&
                   (mode == tap_bridge_pkg::MODE_DISCRETE);

  // read data mux
  always_comb begin
    case (addr_s2)
      `ADDR_CFG_A: rd_mux = cfg_a;
      `ADDR_CFG_B: rd_mux = cfg_b;
      `ADDR_STATUS: rd_mux = {tdi_full, tdo_full, busy, 2'b00, state};
      `ADDR_COMMAND: rd_mux = {1'b0, trst_cmd, 2'b00, opcode};
      `ADDR_TDO_BUF: rd_mux = tdo_buf;
      `ADDR_TDI_BUF: rd_mux = tdi_buf;
      `ADDR_COUNTER: rd_mux = counter;
      default: rd_mux = {4'h0, disc_reg[3:2], tdi_s2, disc_reg[0]};
    endcase
  end

  // host port outputs; ready rests high outside an access
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ready_o <= 1'b1;
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
    end else begin
      ready_o <= !(active && block_cond);
      data_oe_o <= active && rw_s2;
      if (active && rw_s2) begin
        data_o <= rd_mux;
      end
    end
  end

  // configuration and counter writes, held off while busy by the ready logic
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cfg_a <= `RST_CFG_A;
      cfg_b <= `RST_CFG_B;
      counter <= `RST_COUNTER;
    end else if (grant && !rw_s2) begin
      case (addr_s2)
        `ADDR_CFG_A: cfg_a <= data_s2;
        `ADDR_CFG_B: cfg_b <= data_s2;
        `ADDR_COUNTER: counter <= data_s2;
        default: cfg_a <= cfg_a;
      endcase
    end
  end

  // discrete-control register and its tck edges
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || soft_rst) begin
      disc_reg <= `RST_DISCRETE;
      disc_tck <= 1'b0;
    end else if (wr_disc) begin
      disc_reg <= data_s2[3:0];
      disc_tck <= 1'b0;
    end else if (rd_disc) begin
      disc_tck <= 1'b1;
    end
  end

  // stalls: next byte not written yet, or received byte not read yet
  assign stall = tdi_full ||
                 ((state == tap_bridge_pkg::ENG_SHIFT) && (bit_idx == 3'h0) && !tdo_full);
  // free mode runs except during a command stall; gated mode only while a command needs edges
  assign run = (mode == tap_bridge_pkg::MODE_FREE) ? !(busy && stall) :
               (mode == tap_bridge_pkg::MODE_GATED) && busy && !stall;

  // tck generator block
  tck_tick_gen #(.DIV_W(3), .CNT_W(8)) u_tick (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .run_i(run),
    .div_sel_i(cfg_b[`CFGB_DIV_MSB:`CFGB_DIV_LSB]),
    .tick_o(tick)
  );

  assign rise_ev = tick && !phase;
  assign fall_ev = tick && phase;
  assign eng_load = fall_ev && (state == tap_bridge_pkg::ENG_SHIFT) && (bit_idx == 3'h0);

  // internal tck phase
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      phase <= 1'b0;
    end else if (tick) begin
      phase <= !phase;
    end
  end

  // command register and state sequence engine, stepped on falling tck
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || soft_rst) begin
      state <= tap_bridge_pkg::ENG_IDLE;
      opcode <= tap_bridge_pkg::OP_NONE;
      trst_cmd <= 1'b0;
      tms_pat <= 8'h00;
      pat_cnt <= 4'h0;
      bytes_left <= 8'h00;
      bit_idx <= 3'h0;
      tdo_shift <= 8'h00;
      shift_mark <= 1'b0;
      shadow <= 1'b0;
      eng_tms <= 1'b1;
      eng_tdo <= 1'b1;
    end else if (wr_cmd) begin
      trst_cmd <= data_s2[`CMD_TRST_BIT];
      bytes_left <= counter;
      bit_idx <= 3'h0;
      shadow <= 1'b0;
      // unknown, empty or out-of-mode commands finish at once
      case (tap_bridge_pkg::opcode_t'(data_s2[`CMD_OP_MSB:`CMD_OP_LSB]))
        tap_bridge_pkg::OP_TAP_RESET: begin
          if (mode != tap_bridge_pkg::MODE_DISCRETE) begin
            opcode <= tap_bridge_pkg::OP_TAP_RESET;
            state <= tap_bridge_pkg::ENG_PRE;
            tms_pat <= `PAT_TAP_RESET;
            pat_cnt <= `LEN_TAP_RESET;
          end
        end
        tap_bridge_pkg::OP_SCAN_DR, tap_bridge_pkg::OP_SCAN_IR: begin
          if (mode != tap_bridge_pkg::MODE_DISCRETE && counter != 8'h00) begin
            opcode <= tap_bridge_pkg::opcode_t'(data_s2[`CMD_OP_MSB:`CMD_OP_LSB]);
            state <= tap_bridge_pkg::ENG_PRE;
            if (data_s2[`CMD_OP_MSB:`CMD_OP_LSB] == tap_bridge_pkg::OP_SCAN_DR) begin
              tms_pat <= `PAT_SCAN_DR;
              pat_cnt <= `LEN_SCAN_DR;
            end else begin
              tms_pat <= `PAT_SCAN_IR;
              pat_cnt <= `LEN_SCAN_IR;
            end
          end
        end
        tap_bridge_pkg::OP_SHADOW: begin
          // clock held, bytes clocked out on tdo at the divider pace
          if (mode == tap_bridge_pkg::MODE_GATED && counter != 8'h00) begin
            opcode <= tap_bridge_pkg::OP_SHADOW;
            state <= tap_bridge_pkg::ENG_SHIFT;
            shadow <= 1'b1;
          end
        end
        default: opcode <= tap_bridge_pkg::OP_NONE;
      endcase
    end else if (fall_ev) begin
      shift_mark <= 1'b0;
      case (state)
        tap_bridge_pkg::ENG_PRE, tap_bridge_pkg::ENG_POST: begin
          eng_tms <= tms_pat[0];
          tms_pat <= {1'b0, tms_pat[7:1]};
          pat_cnt <= pat_cnt - 4'h1;
          if (pat_cnt == 4'h1) begin
            if (state == tap_bridge_pkg::ENG_POST ||
                opcode == tap_bridge_pkg::OP_TAP_RESET) begin
              state <= tap_bridge_pkg::ENG_DRAIN;
            end else begin
              state <= tap_bridge_pkg::ENG_SHIFT;
            end
          end
        end
        tap_bridge_pkg::ENG_SHIFT: begin
          if (bit_idx == 3'h0) begin
            eng_tdo <= tdo_buf[0];
            tdo_shift <= {1'b0, tdo_buf[7:1]};
          end else begin
            eng_tdo <= tdo_shift[0];
            tdo_shift <= {1'b0, tdo_shift[7:1]};
          end
          shift_mark <= !shadow;
          bit_idx <= bit_idx + 3'h1;
          if (!shadow) begin
            eng_tms <= (bytes_left == 8'h01) && (bit_idx == 3'h7);
          end
          if (bit_idx == 3'h7) begin
            bytes_left <= bytes_left - 8'h01;
            if (bytes_left == 8'h01) begin
              state <= shadow ? tap_bridge_pkg::ENG_DRAIN : tap_bridge_pkg::ENG_POST;
              tms_pat <= `PAT_EXIT;
              pat_cnt <= `LEN_EXIT;
            end
          end
        end
        default: state <= state;
      endcase
    end else if (state == tap_bridge_pkg::ENG_DRAIN && (vline & live_mask) == '0 &&
                 !shift_mark && (phase || shadow)) begin
      // delayed bits in and last tms clocked by a rise; gated tck parks high, except after a shadow command where it parks low
      state <= tap_bridge_pkg::ENG_IDLE;
      opcode <= tap_bridge_pkg::OP_NONE;
      shadow <= 1'b0;
    end
  end

  // output data buffer; host fill wins over engine take
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || soft_rst) begin
      tdo_buf <= 8'h00;
      tdo_full <= 1'b0;
    end else if (wr_tdo) begin
      tdo_buf <= data_s2;
      tdo_full <= 1'b1;
    end else if (eng_load) begin
      tdo_full <= 1'b0;
    end
  end

  // marks of driven bits travel down the line by rising edges
  assign delayed_valid = (rdly == 4'h0) ? shift_mark : vline[rdly - 4'h1];
  // taps past the delay hold spent marks, so drain need not wait for them
  assign live_mask = RDLY_MAX'((32'h1 << rdly) - 32'h1);

  // retiming line
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || soft_rst) begin
      vline <= '0;
    end else if (rise_ev) begin
      vline <= {vline[RDLY_MAX-2:0], shift_mark};
    end
  end

  // input data buffer; engine set wins over host read
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || soft_rst) begin
      tdi_shift <= 8'h00;
      tdi_cnt <= 3'h0;
      tdi_buf <= 8'h00;
      tdi_full <= 1'b0;
    end else begin
      if (rise_ev && delayed_valid) begin
        tdi_shift <= {tdi_s2, tdi_shift[7:1]};
        tdi_cnt <= tdi_cnt + 3'h1;
        if (tdi_cnt == 3'h7) begin
          tdi_buf <= {tdi_s2, tdi_shift[7:1]};
          tdi_full <= 1'b1;
        end else if (rd_tdi) begin
          tdi_full <= 1'b0;
        end
      end else if (rd_tdi) begin
        tdi_full <= 1'b0;
      end
    end
  end

  // tap pins and their enables, all registered
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tck_o <= 1'b0;
      tms_o <= 1'b1;
      tdo_o <= 1'b1;
      trst_n_o <= 1'b1;
      tck_oe_o <= 1'b0;
      tms_oe_o <= 1'b0;
      tdo_oe_o <= 1'b0;
      trst_oe_o <= 1'b0;
    end else begin
      tck_oe_o <= !toe_n_s2;
      tms_oe_o <= !toe_n_s2;
      tdo_oe_o <= !toe_n_s2;
      trst_oe_o <= !toe_n_s2;
      if (mode == tap_bridge_pkg::MODE_DISCRETE) begin
        tck_o <= disc_tck;
        tms_o <= disc_reg[`DISC_TMS_BIT];
        tdo_o <= disc_reg[`DISC_TDO_BIT];
      end else begin
        tck_o <= shadow ? 1'b0 : phase;
        tms_o <= eng_tms;
        tdo_o <= eng_tdo;
      end
      trst_n_o <= !(trst_cmd || ((mode == tap_bridge_pkg::MODE_DISCRETE) &&
                                 disc_reg[`DISC_TRST_BIT]));
    end
  end

endmodule

// >>> testbench/tap_bridge_properties.sv
// port-level assertions for the tap master bridge
`timescale 1ns/1ps
module tap_bridge_checker (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic access_strobe_n_i,
  input wire logic rw_i,
  input wire logic tap_drive_enable_n_i,
  input wire logic data_oe_o,
  input wire logic ready_o,
  input wire logic tck_o,
  input wire logic tck_oe_o,
  input wire logic tms_o,
  input wire logic tms_oe_o,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic trst_n_o,
  input wire logic trst_oe_o
);
  logic last_wr; // direction of the latest host access
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // remember whether the access in progress writes
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      last_wr <= 1'b0;
    end else if (!access_strobe_n_i) begin
      last_wr <= !rw_i;
    end
  end
  // the reset history guard keeps the three-deep past free of reset samples
  oe_follow_a: assert property (!$past(reset_i, 3) |->
    {tck_oe_o, tms_oe_o, tdo_oe_o, trst_oe_o} == {4{!$past(tap_drive_enable_n_i, 3)}})
    else $error("tap enables not following the enable pin");
  tdo_fall_a: assert property ($changed(tdo_o) |-> !tck_o)
    else $error("tdo moved while tck high");
  tms_fall_a: assert property ($changed(tms_o) |-> !tck_o)
    else $error("tms moved while tck high");
  wait_cause_a: assert property ($fell(ready_o) |->
    !access_strobe_n_i && !$past(access_strobe_n_i, 3))
    else $error("ready dropped outside an access");
  ready_end_a: assert property ($rose(access_strobe_n_i) |-> ##[1:4] ready_o)
    else $error("ready not back after strobe end");
  data_release_a: assert property ($rose(access_strobe_n_i) |-> ##[1:5] !data_oe_o)
    else $error("host data bus still driven");
  read_drive_a: assert property ((!access_strobe_n_i && rw_i) [*5] |-> data_oe_o)
    else $error("read not driving the host bus");
  write_float_a: assert property (data_oe_o |-> $past(rw_i, 3))
    else $error("host bus driven during a write");
  trst_cause_a: assert property ($fell(trst_n_o) |-> last_wr && $past(access_strobe_n_i))
    else $error("target reset without a host write");
  cover property ($fell(ready_o));
  cover property ($fell(trst_n_o));
  cover property ($rose(tck_oe_o));
endmodule
bind tap_master_host_bridge tap_bridge_checker chk (.sys_clk_i, .reset_i, .access_strobe_n_i,
  .rw_i, .tap_drive_enable_n_i, .data_oe_o, .ready_o, .tck_o, .tck_oe_o, .tms_o, .tms_oe_o,
  .tdo_o, .tdo_oe_o, .trst_n_o, .trst_oe_o);

// >>> testbench/tap_target_model.sv
// behavioural target chain: one shift stage from tdo back to tdi
`timescale 1ns/1ps
module tap_target_model (
  input wire logic tck_i, // test clock as seen at the target
  input wire logic tdo_i, // serial data from the master
  input wire logic trst_n_i, // target reset, low active
  output logic tdi_o // serial data back to the master
);
  logic held = 1'b1; // bit captured on the last rise
  initial tdi_o = 1'b1;
  // capture on the rising test clock edge
  always @(posedge tck_i) begin
    held <= tdo_i;
  end
  // launch on the fall so the master sees a settled bit at the next rise
  always @(negedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tdi_o <= 1'b1; // released line sits at its pull-up level
    end else begin
      tdi_o <= held;
    end
  end
endmodule

// >>> testbench/tap_master_host_bridge_test.sv
// self-checking bench: host port stimulus against a one-stage target chain
`timescale 1ns/1ps
`include "tap_bridge_params.svh"
module tap_master_host_bridge_test;
  logic sys_clk = 1'b0; // 100 ns period
  logic reset = 1'b1; // held for four cycles
  logic strobe_n = 1'b1; // host strobe, idle high
  logic rw = 1'b1; // host direction, read high
  logic [2:0] addr = 3'h0; // register index
  logic [7:0] wdata = 8'h00; // host write byte
  logic drive_en_n = 1'b1; // tap pins floated until enabled
  logic [7:0] data_o; // bridge read byte
  logic data_oe_o, ready_o, tdi, tck_o, tck_oe_o, tms_o, tms_oe_o, tdo_o, tdo_oe_o; // outputs
  logic trst_n_o, trst_oe_o; // target reset and its enable
  logic [15:0] tms_hist = 16'h0000; // tms at each tck rise, newest in bit 0
  logic [15:0] tdo_hist = 16'h0000; // tdo at each tck rise
  logic [7:0] rd; // last byte read
  logic saw_wait; // ready dropped in the last access
  int rises = 0; // tck rises since cleared
  realtime t_prev = 0.0; // previous tck rise
  realtime t_last = 0.0; // latest tck rise
  int fails = 0;
  int compares = 0;
  int cycles = 0; // hang guard

  tap_master_host_bridge dut (.sys_clk_i(sys_clk), .reset_i(reset), .access_strobe_n_i(strobe_n),
    .rw_i(rw), .addr_i(addr), .data_i(wdata), .data_o(data_o), .data_oe_o(data_oe_o),
    .ready_o(ready_o), .tap_drive_enable_n_i(drive_en_n), .tdi_i(tdi), .tck_o(tck_o),
    .tck_oe_o(tck_oe_o), .tms_o(tms_o), .tms_oe_o(tms_oe_o), .tdo_o(tdo_o),
    .tdo_oe_o(tdo_oe_o), .trst_n_o(trst_n_o), .trst_oe_o(trst_oe_o));
  // the target sees tck and trst only while their enables drive them; tdo reaches it whatever tdo_oe_o is
  tap_target_model tgt (.tck_i(tck_o & tck_oe_o), .tdo_i(tdo_o),
    .trst_n_i(trst_n_o | !trst_oe_o), .tdi_o(tdi));

  // system clock
  always #50 sys_clk = ~sys_clk;
  // cut a hang short; the whole run needs about a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // tms and tdo are stable at a rise, so no ordering hazard here
  always @(posedge tck_o) begin
    tms_hist = {tms_hist[14:0], tms_o};
    tdo_hist = {tdo_hist[14:0], tdo_o};
    rises++;
    t_prev = t_last;
    t_last = $realtime;
  end

  task automatic print_verdict();
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // compare one value and count it
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one host access; the strobe is held until ready is sampled high
  task automatic access(input logic r, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    rw = r;
    addr = a;
    wdata = d;
    strobe_n = 1'b0;
    saw_wait = 1'b0;
    while (n < 5 || ready_o !== 1'b1) begin
      @(posedge sys_clk);
      if (ready_o === 1'b0) saw_wait = 1'b1;
      n++;
      if (n > 4000) begin // a stuck wait counts as a mismatch
        fails++;
        print_verdict();
      end
    end
    rd = data_o;
    @(negedge sys_clk);
    strobe_n = 1'b1;
    // one edge past the effect so outputs it launched are settled
    repeat (5) @(posedge sys_clk);
  endtask
  // poll status until idle, draining returned bytes
  task automatic wait_idle();
    for (int i = 0; i < 60; i++) begin
      access(1'b1, `ADDR_STATUS, 8'h00);
      if (rd[7] === 1'b1) begin
        access(1'b1, `ADDR_TDI_BUF, 8'h00);
      end else if (rd[5] === 1'b0) begin
        break;
      end
    end
  endtask
  // clear the tck history, then issue a command
  task automatic launch(input logic [7:0] cmd);
    @(negedge sys_clk);
    rises = 0;
    tms_hist = 16'h0000;
    tdo_hist = 16'h0000;
    access(1'b0, `ADDR_COMMAND, cmd);
  endtask
  // values out of reset and the free-running rate of clk/16
  task automatic t_reset();
    check("ready", 16'h0001, ready_o);
    check("tap idle", 16'h0007, {tms_o, tdo_o, trst_n_o});
    check("tap float", 16'h0000, {tck_oe_o, tms_oe_o, tdo_oe_o, trst_oe_o});
    access(1'b1, `ADDR_CFG_B, 8'h00);
    check("divisor reg", 16'h0080, rd);
    repeat (24) @(posedge sys_clk);
    check("tck period", 16'h0010, 16'(int'((t_last - t_prev) / 100.0)));
  endtask
  // tap pins follow the drive enable pin
  task automatic t_drive(input logic en_n, input logic [3:0] exp);
    @(negedge sys_clk);
    drive_en_n = en_n;
    repeat (4) @(posedge sys_clk);
    check("tap enables", {12'h000, exp}, {tck_oe_o, tms_oe_o, tdo_oe_o, trst_oe_o});
  endtask
  // gated mode: tms sequence of tap reset and ir scan, no tck rises in shadow, target reset by command
  task automatic t_sequences();
    access(1'b0, `ADDR_CFG_A, 8'h01);
    access(1'b0, `ADDR_COUNTER, 8'h01);
    launch(8'h01);
    wait_idle();
    // gated tck stopped low at the switch, so an opening rise samples idle-high tms
    check("reset tms", 16'h007E, tms_hist);
    access(1'b0, `ADDR_TDO_BUF, 8'h00);
    launch(8'h03);
    wait_idle();
    check("ir tms", 16'h3006, tms_hist);
    access(1'b0, `ADDR_TDO_BUF, 8'h5A);
    launch(8'h04);
    wait_idle();
    check("shadow rises", 16'h0000, 16'(rises));
    access(1'b0, `ADDR_COMMAND, 8'h40);
    check("trst low", 16'h0000, trst_n_o);
    access(1'b0, `ADDR_COMMAND, 8'h00);
    check("trst high", 16'h0001, trst_n_o);
  endtask
  // data scan with a read that must wait for the returned byte
  task automatic t_scan_dr();
    access(1'b0, `ADDR_TDO_BUF, 8'h35);
    launch(8'h02);
    access(1'b1, `ADDR_STATUS, 8'h00);
    check("busy", 16'h0001, rd[5]);
    access(1'b1, `ADDR_COMMAND, 8'h00);
    check("opcode", {12'h000, tap_bridge_pkg::OP_SCAN_DR}, rd[3:0]);
    access(1'b1, `ADDR_TDI_BUF, 8'h00);
    check("tdi wait", 16'h0001, saw_wait);
    check("tdi byte", 16'h0035, rd[7:1]);
    wait_idle();
    check("dr tms", 16'h1006, tms_hist);
    check("dr tdo", 16'h00AC, tdo_hist[9:2]);
  endtask
  // discrete mode: host writes lower tck, reads raise it
  task automatic t_discrete();
    access(1'b0, `ADDR_CFG_A, 8'h02);
    access(1'b0, `ADDR_DISCRETE, 8'h0C);
    check("pins after write", 16'h0004, {tck_o, tms_o, tdo_o, trst_n_o});
    access(1'b1, `ADDR_DISCRETE, 8'h00);
    check("tck after read", 16'h0001, tck_o);
    check("discrete reg", 16'h0006, {rd[7:2], rd[0]});
    access(1'b0, `ADDR_DISCRETE, 8'h01);
    check("pins after write", 16'h0003, {tck_o, tms_o, tdo_o, trst_n_o});
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_drive(1'b0, 4'hF);
    t_sequences();
    t_scan_dr();
    t_discrete();
    t_drive(1'b1, 4'h0);
    print_verdict();
  end
endmodule
